// *** common/als_thresh_pkg.sv ***
/*
 * Constants for the light threshold, persistence and gain configuration block:
 * register offsets, field positions, reset values, timing figures and decode functions.
 * Assumes a byte-wide register port driven by the serial front end of the device.
 */
package als_thresh_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [4:0] OFS_LOW_LIMIT_LOWER = 5'h04;
   localparam logic [4:0] OFS_LOW_LIMIT_UPPER = 5'h05;
   localparam logic [4:0] OFS_HIGH_LIMIT_LOWER = 5'h06;
   localparam logic [4:0] OFS_HIGH_LIMIT_UPPER = 5'h07;
   localparam logic [4:0] OFS_PERSISTENCE = 5'h0C;
   localparam logic [4:0] OFS_CONFIG = 5'h0D;
   localparam logic [4:0] OFS_GAIN_CONTROL = 5'h0F;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int CFG_WAIT_LONG_BIT = 1;
   localparam int CFG_GAIN_LEVEL_BIT = 2;
   localparam logic [3:0] PERSISTENCE_FILTER_RESET = 4'h0;
   localparam logic [7:0] LIMIT_RESET = 8'h00;
   localparam logic [1:0] GAIN_SEL_RESET = 2'h0;
   localparam logic [3:0] PERSISTENCE_FILTER_EVERY = 4'h0;
   localparam logic [3:0] PERSISTENCE_FILTER_LAST_DIRECT = 4'h3;
   localparam logic [5:0] PERSISTENCE_FILTER_STEP = 6'h05;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam real CLK_FREQ_MHZ = 200.0;
   localparam real WAIT_BASE_MS = 2.73;
   localparam int WAIT_BASE_CYCLES = int'(WAIT_BASE_MS * 1000.0 * CLK_FREQ_MHZ);
   localparam int WAIT_LONG_FACTOR = 12;
   localparam int WAIT_CNT_W = 23;

   // ----------------------------------------------------------------
   // Gain, in hundredths of 1x
   // ----------------------------------------------------------------
   localparam logic [13:0] GAIN_1X = 14'h0064;
   localparam logic [13:0] GAIN_8X = 14'h0320;
   localparam logic [13:0] GAIN_16X = 14'h0640;
   localparam logic [13:0] GAIN_120X = 14'h2EE0;
   localparam logic [13:0] GAIN_1X_LOW = 14'h0010;
   localparam logic [13:0] GAIN_8X_LOW = 14'h0080;

   // Consecutive out-of-range results needed for a persistence code
   function automatic logic [5:0] persistence_filter_required(input logic [3:0] code);
      if (code <= PERSISTENCE_FILTER_LAST_DIRECT)
      begin
         persistence_filter_required = {2'h0, code};
      end
      else
      begin
         persistence_filter_required = 6'({2'h0, code} - {2'h0, PERSISTENCE_FILTER_LAST_DIRECT}) * PERSISTENCE_FILTER_STEP;
      end
   endfunction : persistence_filter_required

   function automatic logic [13:0] gain_x100(input logic [1:0] sel, input logic low_level);
      case (sel)
         2'h0: gain_x100 = low_level ? GAIN_1X_LOW : GAIN_1X;
         2'h1: gain_x100 = low_level ? GAIN_8X_LOW : GAIN_8X;
         2'h2: gain_x100 = GAIN_16X;
         default: gain_x100 = GAIN_120X;
      endcase
   endfunction : gain_x100

endpackage : als_thresh_pkg

// *** core/als_thresh_irq.sv ***
/*
 * Light threshold comparison with persistence filter, interrupt flag and pin,
 * gain and wait-step configuration, and their byte-wide registers.
 * Assumes conversion results, strobes and register accesses arrive on core_clk_in.
 */
`timescale 1ns/100ps

module als_thresh_irq
   import als_thresh_pkg::*;
#(
   parameter int WAIT_BASE = WAIT_BASE_CYCLES  // Base wait step in clock cycles
)
(
   input wire logic core_clk_in,               // 200 MHz clock
   input wire logic rst_n_in,                  // Asynchronous reset, active low
   input wire logic reg_wr_in,                 // Register write strobe
   input wire logic reg_rd_in,                 // Register read strobe
   input wire logic [4:0] reg_addr_in,         // Register offset
   input wire logic [7:0] reg_wdata_in,        // Write data
   output logic [7:0] reg_rdata_out,           // Read data, valid after read strobe
   input wire logic irq_clear_cmd_in,          // Interrupt clear special command
   input wire logic light_irq_mask_in,         // Mask bit of the enable register
   input wire logic conv_done_in,              // Conversion cycle completed
   input wire logic [15:0] channel0_count_in,  // Channel-0 result
   input wire logic wait_run_in,               // Wait timer running
   input wire logic irq_pin_in,                // Interrupt wire level
   output logic irq_pin_out,                   // Pin drive value, always low
   output logic irq_pin_oe_out,                // Pin pulled low while high
   output logic irq_line_low_out,              // Synchronised wire observed low
   output logic light_irq_flag_out,            // Status: interrupt asserted
   output logic [1:0] gain_select_out,         // Analog gain selector
   output logic gain_level_scale_out,          // Low gain level bit
   output logic [13:0] gain_x100_out,          // Effective gain in hundredths
   output logic wait_long_out,                 // Wait-long bit
   output logic wait_step_tick_out             // One pulse per finished wait step
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] limit_bytes_q [4];
   logic [3:0] persistence_filter_code_q;
   logic [15:0] low_limit;
   logic [15:0] high_limit;

   assign low_limit = {limit_bytes_q[1], limit_bytes_q[0]};
   assign high_limit = {limit_bytes_q[3], limit_bytes_q[2]};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_limit
         always_ff @(posedge core_clk_in or negedge rst_n_in)
         begin
            if (!rst_n_in)
            begin
               limit_bytes_q[gi] <= LIMIT_RESET;
            end
            else if (reg_wr_in && reg_addr_in == OFS_LOW_LIMIT_LOWER + 5'(gi))
            begin
               limit_bytes_q[gi] <= reg_wdata_in;
            end
         end
      end
   endgenerate

   // Reserved bits are not stored, so they read back as zero
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         persistence_filter_code_q <= PERSISTENCE_FILTER_RESET;
         gain_level_scale_out <= 1'b0;
         wait_long_out <= 1'b0;
         gain_select_out <= GAIN_SEL_RESET;
      end
      else if (reg_wr_in)
      begin
         case (reg_addr_in)
            OFS_PERSISTENCE: persistence_filter_code_q <= reg_wdata_in[3:0];
            OFS_CONFIG:
            begin
               gain_level_scale_out <= reg_wdata_in[CFG_GAIN_LEVEL_BIT];
               wait_long_out <= reg_wdata_in[CFG_WAIT_LONG_BIT];
            end
            OFS_GAIN_CONTROL: gain_select_out <= reg_wdata_in[1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         reg_rdata_out <= 8'h00;
      end
      else if (reg_rd_in)
      begin
         case (reg_addr_in)
            OFS_LOW_LIMIT_LOWER: reg_rdata_out <= limit_bytes_q[0];
            OFS_LOW_LIMIT_UPPER: reg_rdata_out <= limit_bytes_q[1];
            OFS_HIGH_LIMIT_LOWER: reg_rdata_out <= limit_bytes_q[2];
            OFS_HIGH_LIMIT_UPPER: reg_rdata_out <= limit_bytes_q[3];
            OFS_PERSISTENCE: reg_rdata_out <= {4'h0, persistence_filter_code_q};
            OFS_CONFIG: reg_rdata_out <= {5'h00, gain_level_scale_out, wait_long_out, 1'b0};
            OFS_GAIN_CONTROL: reg_rdata_out <= {6'h00, gain_select_out};
            default: reg_rdata_out <= 8'h00;
         endcase
      end
   end

   // Scaling only defined for the two lowest gains; higher codes ignore it
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         gain_x100_out <= GAIN_1X;
      end
      else
      begin
         gain_x100_out <= gain_x100(gain_select_out, gain_level_scale_out);
      end
   end

   // ----------------------------------------------------------------
   // Threshold compare and persistence
   // ----------------------------------------------------------------
   logic out_of_range;
   logic [5:0] oor_cnt_q;
   logic [5:0] oor_cnt_inc;
   logic persist_hit;

   assign out_of_range = (channel0_count_in < low_limit) || (channel0_count_in > high_limit);
   assign oor_cnt_inc = (oor_cnt_q == 6'h3F) ? oor_cnt_q : oor_cnt_q + 6'h01;
   assign persist_hit = (persistence_filter_code_q == PERSISTENCE_FILTER_EVERY) ||
                        (out_of_range && oor_cnt_inc >= persistence_filter_required(persistence_filter_code_q));

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         oor_cnt_q <= 6'h00;
      end
      else if (conv_done_in)
      begin
         oor_cnt_q <= out_of_range ? oor_cnt_inc : 6'h00;
      end
      else if (irq_clear_cmd_in)
      begin
         oor_cnt_q <= 6'h00;
      end
   end

   // A hit in the clear cycle wins, so no event is lost
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         light_irq_flag_out <= 1'b0;
      end
      else if (conv_done_in && persist_hit)
      begin
         light_irq_flag_out <= 1'b1;
      end
      else if (irq_clear_cmd_in)
      begin
         light_irq_flag_out <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt pin
   // ----------------------------------------------------------------
   logic irq_sync1_q;

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         irq_pin_out <= 1'b0;
         irq_pin_oe_out <= 1'b0;
         irq_sync1_q <= 1'b1;
         irq_line_low_out <= 1'b0;
      end
      else
      begin
         irq_pin_out <= 1'b0;
         irq_pin_oe_out <= light_irq_flag_out && light_irq_mask_in;
         irq_sync1_q <= irq_pin_in;
         irq_line_low_out <= !irq_sync1_q;
      end
   end

   // ----------------------------------------------------------------
   // Wait step timer
   // ----------------------------------------------------------------
   logic [WAIT_CNT_W-1:0] wait_cnt_q;
   logic [WAIT_CNT_W-1:0] step_last;

   assign step_last = wait_long_out ? WAIT_CNT_W'(WAIT_BASE * WAIT_LONG_FACTOR - 1)
                                    : WAIT_CNT_W'(WAIT_BASE - 1);

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wait_cnt_q <= '0;
         wait_step_tick_out <= 1'b0;
      end
      else if (!wait_run_in)
      begin
         wait_cnt_q <= '0;
         wait_step_tick_out <= 1'b0;
      end
      else if (wait_cnt_q >= step_last)
      begin
         wait_cnt_q <= '0;
         wait_step_tick_out <= 1'b1;
      end
      else
      begin
         wait_cnt_q <= wait_cnt_q + WAIT_CNT_W'(1);
         wait_step_tick_out <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_conv_code(logic [3:0] c);
      conv_done_in && persistence_filter_code_q == c;
   endsequence

   sequence s_clear_only;
      irq_clear_cmd_in && !conv_done_in;
   endsequence

   property p_every_conv;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      s_conv_code(4'h0) |=> light_irq_flag_out;
   endproperty
   a_every_conv: assert property (p_every_conv) else $error("Code zero conversion gave no interrupt");

   property p_single;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      s_conv_code(4'h1) ##0 out_of_range |=> light_irq_flag_out;
   endproperty
   a_single: assert property (p_single) else $error("Single out-of-range result gave no interrupt");

   property p_two;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      s_conv_code(4'h2) ##0 (out_of_range && oor_cnt_q == 6'h01) |=> light_irq_flag_out;
   endproperty
   a_two: assert property (p_two) else $error("Second out-of-range result gave no interrupt");

   property p_sixty;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      s_conv_code(4'hF) ##0 (out_of_range && oor_cnt_q == 6'h3A && !light_irq_flag_out && !irq_clear_cmd_in)
      |=> !light_irq_flag_out;
   endproperty
   a_sixty: assert property (p_sixty) else $error("Interrupt before sixty results");

   property p_in_range_restart;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      conv_done_in && !out_of_range |=> oor_cnt_q == 6'h00;
   endproperty
   a_in_range_restart: assert property (p_in_range_restart) else $error("Counter not restarted");

   property p_clear;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      s_clear_only |=> !light_irq_flag_out && oor_cnt_q == 6'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("Clear command did not clear");

   property p_pending_holds;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      light_irq_flag_out && !irq_clear_cmd_in |=> light_irq_flag_out;
   endproperty
   a_pending_holds: assert property (p_pending_holds) else $error("Interrupt dropped without clear");

   property p_pin_mask;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      ##1 irq_pin_oe_out == ($past(light_irq_flag_out) && $past(light_irq_mask_in));
   endproperty
   a_pin_mask: assert property (p_pin_mask) else $error("Pin does not follow masked flag");

   property p_gain;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      reg_wr_in && reg_addr_in == OFS_GAIN_CONTROL && reg_wdata_in[1:0] == 2'h3 ##1 !reg_wr_in
      |=> gain_x100_out == GAIN_120X;
   endproperty
   a_gain: assert property (p_gain) else $error("Gain code three not 120x");

   property p_persistence_filter_read;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      reg_rd_in && reg_addr_in == OFS_PERSISTENCE |=> reg_rdata_out == {4'h0, $past(persistence_filter_code_q)};
   endproperty
   a_persistence_filter_read: assert property (p_persistence_filter_read) else $error("Persistence readback wrong");

   property p_step_len;
      @(posedge core_clk_in) disable iff (!rst_n_in)
      wait_step_tick_out |-> $past(wait_cnt_q) == $past(step_last);
   endproperty
   a_step_len: assert property (p_step_len) else $error("Wait step length wrong");

endmodule : als_thresh_irq

// *** tb/als_host_model.sv ***
/* Host model: byte register writer and reader, clear command, interrupt wire.
   Assumes one shared clock; the bench calls the tasks hierarchically. */
`timescale 1ns/100ps
module als_host_model
   import als_thresh_pkg::*;
(
   input wire logic core_clk_in,         // Device clock
   output logic reg_wr_out = 1'b0,       // Write strobe
   output logic reg_rd_out = 1'b0,       // Read strobe
   output logic [4:0] reg_addr_out = 5'h00, // Register offset
   output logic [7:0] reg_wdata_out = 8'h00, // Write data
   output logic irq_clear_cmd_out = 1'b0, // Clear command pulse
   input wire logic [7:0] reg_rdata_in,  // Read data
   input wire logic irq_pin_in,          // Device drive value
   input wire logic irq_pin_oe_in,       // Device drive enable
   output logic irq_wire_out             // Wire level
);
   logic [1:0] gain_sel_shadow = 2'h0;

   // Pull-up: only the device can pull the line low
   assign irq_wire_out = (irq_pin_oe_in === 1'b1 && irq_pin_in === 1'b0) ? 1'b0 : 1'b1;

   task automatic write_reg(input logic [4:0] a, input logic [7:0] data);
      logic [7:0] d;
      d = data;
      if (a == OFS_PERSISTENCE) d = d & 8'h0F;
      if (a == OFS_CONFIG) d = d & 8'h06;
      if (a == OFS_GAIN_CONTROL) d = d & 8'h03;
      if (a == OFS_CONFIG && gain_sel_shadow > 2'h1) d[CFG_GAIN_LEVEL_BIT] = 1'b0;
      if (a == OFS_GAIN_CONTROL) gain_sel_shadow = d[1:0];
      @(posedge core_clk_in);
      reg_wr_out <= 1'b1;
      reg_addr_out <= a;
      reg_wdata_out <= d;
      @(posedge core_clk_in);
      reg_wr_out <= 1'b0;
      reg_wdata_out <= ~d;
   endtask : write_reg

   task automatic read_reg(input logic [4:0] a, output logic [7:0] d);
      @(posedge core_clk_in);
      reg_rd_out <= 1'b1;
      reg_addr_out <= a;
      @(posedge core_clk_in);
      reg_rd_out <= 1'b0;
      reg_addr_out <= ~a;
      #1;
      d = reg_rdata_in;
   endtask : read_reg

   // One pulse clears; no write follows it
   task automatic clear_irq();
      @(posedge core_clk_in);
      irq_clear_cmd_out <= 1'b1;
      @(posedge core_clk_in);
      irq_clear_cmd_out <= 1'b0;
   endtask : clear_irq
endmodule : als_host_model

// *** tb/als_threshold_interrupt_config_bench.sv ***
/* Bench for the light threshold block: limits, persistence, mask, gain, wait steps.
   Assumes the host model owns the register port and the interrupt wire. */
`timescale 1ns/100ps
module als_threshold_interrupt_config_bench
   import als_thresh_pkg::*;
;
   localparam int WB = 4;
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic reg_wr, reg_rd, irq_clear, irq_pin, irq_oe, irq_wire, line_low, irq_flag, gain_level, wait_long, wait_tick;
   logic [4:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic light_irq_mask = 1'b0;
   logic conv_done = 1'b0;
   logic [15:0] channel0_count = 16'h0000;
   logic wait_run = 1'b0;
   logic [1:0] gain_sel;
   logic [13:0] gain_x100;
   int err_count = 0;
   int comparisons = 0;

   always #2.5 core_clk_in = ~core_clk_in;

   als_thresh_irq #(.WAIT_BASE(WB)) als_thresh_irq_inst (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
      .reg_rdata_out(reg_rdata), .irq_clear_cmd_in(irq_clear), .light_irq_mask_in(light_irq_mask),
      .conv_done_in(conv_done), .channel0_count_in(channel0_count), .wait_run_in(wait_run),
      .irq_pin_in(irq_wire), .irq_pin_out(irq_pin), .irq_pin_oe_out(irq_oe), .irq_line_low_out(line_low),
      .light_irq_flag_out(irq_flag), .gain_select_out(gain_sel), .gain_level_scale_out(gain_level),
      .gain_x100_out(gain_x100), .wait_long_out(wait_long), .wait_step_tick_out(wait_tick));

   als_host_model als_host_model_inst (.core_clk_in(core_clk_in), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
      .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata), .irq_clear_cmd_out(irq_clear),
      .reg_rdata_in(reg_rdata), .irq_pin_in(irq_pin), .irq_pin_oe_in(irq_oe), .irq_wire_out(irq_wire));

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask : chk

   task automatic settle();
      repeat (4) @(posedge core_clk_in);
      #1;
   endtask : settle

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      als_host_model_inst.write_reg(a, d);
   endtask : wr

   task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] v;
      als_host_model_inst.read_reg(a, v);
      chk($sformatf("register %h", a), {8'h00, exp}, {8'h00, v});
   endtask : rd_chk

   task automatic convert(input logic [15:0] v);
      @(posedge core_clk_in);
      conv_done <= 1'b1;
      channel0_count <= v;
      @(posedge core_clk_in);
      conv_done <= 1'b0;
      channel0_count <= ~v;
   endtask : convert

   // Gap between the first two ticks; the time up to the first tick after a restart is skipped
   task automatic tick_gap(input int exp);
      int n;
      n = 0;
      while (wait_tick !== 1'b1 && n < 200)
      begin
         @(posedge core_clk_in);
         #1;
         n++;
      end
      n = 0;
      do
      begin
         @(posedge core_clk_in);
         #1;
         n++;
      end
      while (wait_tick !== 1'b1 && n < 200);
      chk("tick period", 16'(exp), 16'(n));
   endtask : tick_gap

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset();
      logic [4:0] ofs [8];
      ofs = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h0C, 5'h0D, 5'h0F, 5'h10};
      foreach (ofs[i]) rd_chk(ofs[i], 8'h00);
      chk("gain x100", 16'h0064, {2'h0, gain_x100});
      chk("idle wire", 16'h0001, {15'h0, irq_wire});
   endtask : t_reset

   task automatic t_limits();
      logic [15:0] vals [6];
      logic hit [6];
      vals = '{16'h00FF, 16'h0100, 16'h8000, 16'h8001, 16'h0000, 16'hFFFF};
      hit = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
      wr(OFS_LOW_LIMIT_UPPER, 8'h01);
      wr(OFS_HIGH_LIMIT_UPPER, 8'h80);
      rd_chk(OFS_LOW_LIMIT_UPPER, 8'h01);
      rd_chk(OFS_HIGH_LIMIT_UPPER, 8'h80);
      wr(OFS_PERSISTENCE, 8'h01);
      light_irq_mask <= 1'b1;
      foreach (vals[i])
      begin
         als_host_model_inst.clear_irq();
         convert(vals[i]);
         settle();
         chk("flag", {15'h0, hit[i]}, {15'h0, irq_flag});
         chk("wire", {15'h0, !hit[i]}, {15'h0, irq_wire});
         chk("line low", {15'h0, hit[i]}, {15'h0, line_low});
      end
   endtask : t_limits

   task automatic t_persist();
      int n;
      for (int c = 0; c < 16; c++)
      begin
         n = (c == 0) ? 1 : (c <= 3) ? c : (c - 3) * 5;
         wr(OFS_PERSISTENCE, 8'(c));
         rd_chk(OFS_PERSISTENCE, 8'(c));
         als_host_model_inst.clear_irq();
         repeat (n - 1) convert(16'h0010);
         settle();
         chk("flag short", 16'h0000, {15'h0, irq_flag});
         convert((c == 0) ? 16'h1000 : 16'h0010);
         settle();
         chk("flag full", 16'h0001, {15'h0, irq_flag});
      end
   endtask : t_persist

   task automatic t_restart();
      wr(OFS_PERSISTENCE, 8'h03);
      als_host_model_inst.clear_irq();
      convert(16'h0010);
      convert(16'h0010);
      convert(16'h1000);
      convert(16'h0010);
      convert(16'h0010);
      settle();
      chk("flag restart", 16'h0000, {15'h0, irq_flag});
      convert(16'h0010);
      settle();
      chk("flag third", 16'h0001, {15'h0, irq_flag});
   endtask : t_restart

   task automatic t_mask();
      @(posedge core_clk_in);
      light_irq_mask <= 1'b0;
      repeat (20) settle();
      chk("masked wire", 16'h0001, {15'h0, irq_wire});
      chk("flag held", 16'h0001, {15'h0, irq_flag});
      @(posedge core_clk_in);
      light_irq_mask <= 1'b1;
      settle();
      chk("unmasked wire", 16'h0000, {15'h0, irq_wire});
      chk("pin value", 16'h0000, {15'h0, irq_pin});
      als_host_model_inst.clear_irq();
      settle();
      chk("cleared flag", 16'h0000, {15'h0, irq_flag});
      chk("cleared wire", 16'h0001, {15'h0, irq_wire});
   endtask : t_mask

   task automatic t_gain();
      logic [13:0] g [4];
      g = '{14'h0064, 14'h0320, 14'h0640, 14'h2EE0};
      for (int s = 0; s < 4; s++)
      begin
         wr(OFS_GAIN_CONTROL, 8'(s));
         settle();
         chk("gain sel", 16'(s), {14'h0, gain_sel});
         chk("gain", {2'h0, g[s]}, {2'h0, gain_x100});
      end
      for (int s = 0; s < 2; s++)
      begin
         wr(OFS_GAIN_CONTROL, 8'(s));
         wr(OFS_CONFIG, 8'h04);
         settle();
         chk("gain level", 16'h0001, {15'h0, gain_level});
         chk("scaled gain", (s == 1) ? 16'h0080 : 16'h0010, {2'h0, gain_x100});
         wr(OFS_CONFIG, 8'h00);
      end
   endtask : t_gain

   task automatic t_wait();
      wait_run <= 1'b1;
      tick_gap(WB);
      wr(OFS_CONFIG, 8'h02);
      wait_run <= 1'b0;
      settle();
      chk("wait long", 16'h0001, {15'h0, wait_long});
      rd_chk(OFS_CONFIG, 8'h02);
      wait_run <= 1'b1;
      tick_gap(12 * WB);
   endtask : t_wait

   task automatic close_out();
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out

   initial
   begin
      repeat (8) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      t_reset();
      t_limits();
      t_persist();
      t_restart();
      t_mask();
      t_gain();
      t_wait();
      close_out();
   end

   initial
   begin
      #400000;
      err_count++;
      close_out();
   end
endmodule : als_threshold_interrupt_config_bench
